// *** rtl/snpi_pkg.sv ***
package snpi_pkg;

    // ==========================================================
    // Lane modes
    // ==========================================================
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL   = 2'h1;
    localparam logic [1:0] MODE_QUAD   = 2'h2;

    // ==========================================================
    // Serial framing
    // ==========================================================
    localparam int         BYTE_BITS   = 8;
    localparam logic [3:0] CNT_ZERO    = 4'h0;
    localparam logic [3:0] CNT_FULL    = 4'h8;
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic [3:0] OE_NONE     = 4'h0;
    localparam logic [3:0] OE_SINGLE   = 4'h2;
    localparam logic [3:0] OE_DUAL     = 4'h3;
    localparam logic [3:0] OE_QUAD     = 4'hF;

    // Bits moved per clock edge for a lane mode
    function automatic logic [3:0] lane_step(input logic [1:0] mode);
        case (mode)
            MODE_DUAL: lane_step = 4'h2;
            MODE_QUAD: lane_step = 4'h4;
            default:   lane_step = 4'h1;
        endcase
    endfunction

endpackage

// *** rtl/snpi_ctl_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface snpi_ctl_if;
    logic sclk;
    logic hold_n;
    logic selected;
    logic quad_cmd;
    logic deselect;
    logic paused;
    logic quad_lock;

    modport pause
    (
        input  sclk,
        input  hold_n,
        input  selected,
        input  quad_cmd,
        input  deselect,
        output paused,
        output quad_lock
    );

    modport top
    (
        output sclk,
        output hold_n,
        output selected,
        output quad_cmd,
        output deselect,
        input  paused,
        input  quad_lock
    );
endinterface
`default_nettype wire

// *** rtl/snpi_pause.sv ***
`timescale 1ns/1ps
`default_nettype none
module snpi_pause
(
    input  wire logic  ref_clk,
    input  wire logic  rst_b,
    snpi_ctl_if.pause  ctl
);

    logic paused_q;
    logic quad_lock_q;
    logic want_pause;

    assign ctl.paused    = paused_q;
    assign ctl.quad_lock = quad_lock_q;

    // ==========================================================
    // Quad lock
    // ==========================================================
    // quad takes pause pin
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || ctl.deselect)
            quad_lock_q <= 1'b0;
        else if (ctl.selected && ctl.quad_cmd)
            quad_lock_q <= 1'b1;
    end

    // ==========================================================
    // Pause state
    // ==========================================================
    // pause only while selected
    assign want_pause = ctl.selected && !ctl.hold_n && !quad_lock_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || ctl.deselect || quad_lock_q)
            paused_q <= 1'b0;
        else if (!ctl.sclk)
            paused_q <= want_pause;
    end

    a_pause_clk_low : assert property (@(posedge ref_clk) disable iff (!rst_b)
        $changed(paused_q) |-> !$past(ctl.sclk) || $past(ctl.deselect) || $past(quad_lock_q))
        else $error("pause changed while clock high");

    a_quad_no_pause : assert property (@(posedge ref_clk) disable iff (!rst_b)
        quad_lock_q |=> !paused_q)
        else $error("pause honoured during quad lock");

endmodule
`default_nettype wire

// *** rtl/snpi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module snpi_top
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic [3:0] io_i,
    output logic      [3:0] io_o,
    output logic      [3:0] io_oe,
    input  wire logic [1:0] lane_mode,
    input  wire logic       quad_cmd,
    input  wire logic       drive_phase,
    input  wire logic [7:0] tx_byte,
    input  wire logic       wp_enable,
    input  wire logic [3:0] block_protect_field,
    input  wire logic [1:0] status_protect_field,
    input  wire logic       busy_in,
    output logic            selected,
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    output logic            tx_take,
    output logic            paused,
    output logic            prot_reg_guard,
    output logic            write_block,
    output logic            region_guard,
    output logic            quad_enabled,
    output logic            internal_busy
);

    logic       sclk_q;
    logic       cs_n_q;
    logic       armed_q;
    logic [7:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic [7:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic       rise;
    logic       fall;
    logic       sel;
    logic       live;
    logic       out_en;
    logic [1:0] eff_mode;
    logic [3:0] step;
    logic [7:0] rx_d;
    logic [3:0] rx_cnt_d;
    logic [7:0] tx_word;
    logic       wp_n;

    snpi_ctl_if ctl ();

    snpi_pause u_pause
    (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .ctl     (ctl)
    );

    // ==========================================================
    // Pin edges and selection
    // ==========================================================
    // both idle levels give same edges
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk;
            cs_n_q <= cs_n;
        end
    end

    assign rise = sclk && !sclk_q;
    assign fall = !sclk && sclk_q;

    // arm only on a seen falling edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            armed_q <= 1'b0;
        else if (cs_n_q && !cs_n)
            armed_q <= 1'b1;
    end

    assign sel = armed_q && !cs_n;

    assign ctl.sclk     = sclk;
    // pause input relies on host drive
    assign ctl.hold_n   = io_i[3];
    assign ctl.selected = sel;
    assign ctl.quad_cmd = quad_cmd && !wp_enable;
    assign ctl.deselect = cs_n;

    assign live = sel && !ctl.paused;

    // quad lanes only under quad lock
    assign eff_mode = (lane_mode == snpi_pkg::MODE_QUAD && (!ctl.quad_lock || wp_enable))
                    ? snpi_pkg::MODE_SINGLE : lane_mode;
    assign step     = snpi_pkg::lane_step(eff_mode);

    assign out_en = live && drive_phase;

    // ==========================================================
    // Receive shifter
    // ==========================================================
    always_comb
    begin
        rx_cnt_d = rx_cnt_q + step;
        case (eff_mode)
            snpi_pkg::MODE_DUAL: rx_d = {rx_sh_q[5:0], io_i[1:0]};
            snpi_pkg::MODE_QUAD: rx_d = {rx_sh_q[3:0], io_i[3:0]};
            default:             rx_d = {rx_sh_q[6:0], io_i[0]};
        endcase
    end

    // wide lanes sample on rising edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || cs_n)
        begin
            rx_sh_q  <= snpi_pkg::BYTE_RESET;
            rx_cnt_q <= snpi_pkg::CNT_ZERO;
            rx_byte  <= snpi_pkg::BYTE_RESET;
            rx_valid <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (rise && live && !drive_phase)
            begin
                rx_sh_q <= rx_d;
                if (rx_cnt_d == snpi_pkg::CNT_FULL)
                begin
                    rx_cnt_q <= snpi_pkg::CNT_ZERO;
                    rx_byte  <= rx_d;
                    rx_valid <= 1'b1;
                end
                else
                    rx_cnt_q <= rx_cnt_d;
            end
        end
    end

    // ==========================================================
    // Transmit shifter
    // ==========================================================
    assign tx_word = (tx_cnt_q == snpi_pkg::CNT_ZERO) ? tx_byte : tx_sh_q;

    // single lane changes on falling edge
    // wide lanes change on falling edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || cs_n)
        begin
            tx_sh_q  <= snpi_pkg::BYTE_RESET;
            tx_cnt_q <= snpi_pkg::CNT_ZERO;
            io_o     <= snpi_pkg::OE_NONE;
            tx_take  <= 1'b0;
        end
        else
        begin
            tx_take <= 1'b0;
            if (fall && out_en)
            begin
                tx_take  <= (tx_cnt_q == snpi_pkg::CNT_ZERO);
                tx_sh_q  <= tx_word << step;
                tx_cnt_q <= (tx_cnt_q + step) & 4'h7;
                case (eff_mode)
                    snpi_pkg::MODE_DUAL: io_o <= {2'h0, tx_word[7:6]};
                    snpi_pkg::MODE_QUAD: io_o <= tx_word[7:4];
                    default:             io_o <= {2'h0, tx_word[7], 1'b0};
                endcase
            end
        end
    end

    // ==========================================================
    // Output enables
    // ==========================================================
    // float everything when deselected
    // lanes as inputs outside output phase
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || cs_n || !out_en)
            io_oe <= snpi_pkg::OE_NONE;
        else
            case (eff_mode)
                snpi_pkg::MODE_DUAL: io_oe <= snpi_pkg::OE_DUAL;
                snpi_pkg::MODE_QUAD: io_oe <= snpi_pkg::OE_QUAD;
                default:             io_oe <= snpi_pkg::OE_SINGLE;
            endcase
    end

    // ==========================================================
    // Write protection and status
    // ==========================================================
    // Protect pin is data while quad owns it
    assign wp_n = ctl.quad_lock ? 1'b1 : io_i[2];

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            selected       <= 1'b0;
            paused         <= 1'b0;
            prot_reg_guard <= 1'b0;
            write_block    <= 1'b0;
            region_guard   <= 1'b0;
            quad_enabled   <= 1'b0;
            internal_busy  <= 1'b0;
        end
        else
        begin
            selected       <= sel;
            paused         <= ctl.paused;
            prot_reg_guard <= !wp_n;
            write_block    <= wp_enable && !io_i[2];
            // pin plus fields guard a region
            region_guard   <= !wp_n && (status_protect_field != 2'h0)
                              && (block_protect_field != 4'h0);
            quad_enabled   <= !wp_enable;
            internal_busy  <= busy_in;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_deselect;
        cs_n;
    endsequence

    a_desel_float : assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_deselect |=> io_oe == snpi_pkg::OE_NONE)
        else $error("lanes driven while deselected");

    a_arm_on_fall : assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(armed_q) |-> $past(cs_n_q) && !$past(cs_n))
        else $error("armed without chip-select fall");

    a_rx_on_rise : assert property (@(posedge ref_clk) disable iff (!rst_b)
        rx_valid |-> $past(rise) && $past(sel))
        else $error("byte taken without rising edge");

    a_tx_on_fall : assert property (@(posedge ref_clk) disable iff (!rst_b)
        $changed(io_o) && !$past(cs_n) |-> $past(fall))
        else $error("output changed off falling edge");

    a_quad_gate : assert property (@(posedge ref_clk) disable iff (!rst_b)
        io_oe == snpi_pkg::OE_QUAD |-> !$past(wp_enable))
        else $error("quad drive under hardware protect");

    a_pause_float : assert property (@(posedge ref_clk) disable iff (!rst_b)
        ctl.paused |=> io_oe == snpi_pkg::OE_NONE)
        else $error("lanes driven during pause");

    a_wp_block : assert property (@(posedge ref_clk) disable iff (!rst_b)
        wp_enable && !io_i[2] |=> write_block)
        else $error("writes not blocked by protect pin");

    a_busy_keep : assert property (@(posedge ref_clk) disable iff (!rst_b)
        busy_in && cs_n ##1 busy_in |=> internal_busy [*1])
        else $error("busy lost on deselect");

    a_drive_phase : assert property (@(posedge ref_clk) disable iff (!rst_b)
        io_oe != snpi_pkg::OE_NONE |-> $past(drive_phase) && $past(sel))
        else $error("lanes driven outside output phase");

endmodule
`default_nettype wire

// *** testbench/snpi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module snpi_host
(
    input  wire logic       ref_clk,
    output logic            cs_n,
    output logic            sclk,
    output logic      [3:0] io_i,
    input  wire logic [3:0] io_o,
    input  wire logic [3:0] io_oe
);
    logic       wp_n = 1'b1;
    logic       tog  = 1'b0;
    logic       qd   = 1'b0;
    logic [3:0] hv   = 4'hF;
    logic [3:0] hen  = 4'hD;
    logic [3:0] drv;

    initial
    begin
        cs_n = 1'b0;
        sclk = 1'b0;
    end

    always @(posedge ref_clk) tog <= ~tog;

    // ==========================================================
    // Wire level
    // ==========================================================
    // pause line idles high; send pulls it low at hold_at and quad transfers use it as data
    always_comb
    begin
        drv = qd ? hv : {hv[3], wp_n, hv[1:0]};
        for (int b = 0; b < 4; b++)
            io_i[b] = io_oe[b] ? io_o[b] : (hen[b] ? drv[b] : tog);
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic start(input logic idle);
        sclk <= idle;
        cs_n <= 1'b1;
        ticks(2);
        cs_n <= 1'b0;
        ticks(3);
    endtask

    task automatic stop(input logic idle);
        sclk <= idle;
        hv   <= 4'hF;
        hen  <= 4'hD;
        ticks(1);
        cs_n <= 1'b1;
        ticks(2);
    endtask

    // ==========================================================
    // Transfers
    // ==========================================================
    // data set while clock low
    task automatic send(input logic [7:0] b, input int w, input int hold_at);
        logic [7:0] s;
        logic [3:0] c;
        qd  <= (w == 4);
        hen <= (w == 1) ? 4'hD : 4'hF;
        for (int k = 0; k < 8 / w; k++)
        begin
            s = b << (k * w);
            c = (w == 4) ? s[7:4] : {2'h3, s[7:6] >> (2 - w)};
            sclk <= 1'b0;
            hv   <= c;
            ticks(2);
            if (k == hold_at)
            begin
                // Junk on IO0 proves the paused rise is ignored
                hv <= c ^ 4'h9;
                ticks(2);
                sclk <= 1'b1;
                ticks(3);
                sclk <= 1'b0;
                ticks(3);
                hv <= c;
                ticks(3);
            end
            sclk <= 1'b1;
            ticks(2);
        end
        qd <= 1'b0;
    endtask

    task automatic recv(input int w, output logic [7:0] b, output logic [3:0] oe);
        logic [3:0] v;
        hen <= (w == 1) ? 4'hD : ((w == 2) ? 4'hC : 4'h0);
        b = 8'h00;
        oe = 4'h0;
        for (int k = 0; k < 8 / w; k++)
        begin
            sclk <= 1'b0;
            ticks(4);
            v = (w == 1) ? {3'h0, io_i[1]} : ((w == 2) ? {2'h0, io_i[1:0]} : io_i);
            b = (b << w) | {4'h0, v};
            oe = io_oe;
            sclk <= 1'b1;
            ticks(2);
        end
        hen <= 4'hD;
    endtask
endmodule
`default_nettype wire

// *** testbench/serial_nand_pin_interface_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_nand_pin_interface_test;
    logic        ref_clk = 1'b0;
    logic        rst_b, cs_n, sclk, quad_cmd, drive_phase, wp_enable, busy_in;
    logic        selected, rx_valid, tx_take, paused, prot_reg_guard;
    logic        write_block, region_guard, quad_enabled, internal_busy;
    logic [3:0]  io_i, io_o, io_oe, bpf, oe, oe_x;
    logic [1:0]  lane_mode, spf;
    logic [7:0]  tx_byte, rx_byte, d, t, r;
    logic [7:0]  exp_q[$];
    int          seed, miscompares, tests_run, p0, w;
    int          pause_cnt = 0;
    int          take_cnt  = 0;

    always #2 ref_clk = ~ref_clk;

    snpi_top DUT
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk), .io_i(io_i), .io_o(io_o),
        .io_oe(io_oe), .lane_mode(lane_mode), .quad_cmd(quad_cmd), .drive_phase(drive_phase),
        .tx_byte(tx_byte), .wp_enable(wp_enable), .block_protect_field(bpf),
        .status_protect_field(spf), .busy_in(busy_in), .selected(selected), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_take(tx_take), .paused(paused), .prot_reg_guard(prot_reg_guard),
        .write_block(write_block), .region_guard(region_guard), .quad_enabled(quad_enabled),
        .internal_busy(internal_busy)
    );

    snpi_host u_host
    (
        .ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .io_i(io_i), .io_o(io_o), .io_oe(io_oe)
    );

    // ==========================================================
    // Checking
    // ==========================================================
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        if (paused === 1'b1)
            pause_cnt <= pause_cnt + 1;
        if (tx_take === 1'b1)
            take_cnt <= take_cnt + 1;
        if (rx_valid === 1'b1)
            check(exp_q.size() != 0 && rx_byte === exp_q.pop_front(), "received byte");
    end

    initial
    begin
        repeat (50000) @(posedge ref_clk);
        check(1'b0, "timeout");
        complete_run();
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial
    begin
        seed = 32'h08BFDD49;
        rst_b = 1'b0;
        // Random levels before arming must not select or move data; quad_enabled and internal_busy still follow them, write_block stays low
        {quad_cmd, drive_phase, wp_enable, busy_in, lane_mode, spf, bpf, tx_byte} = 20'($random(seed));
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        u_host.send(8'hA5, 1, 9);
        u_host.stop(1'b0);
        u_host.ticks(3);
        check(io_oe === snpi_pkg::OE_NONE && selected === 1'b0, "deselected pins");
        $display("test arming done");
        drive_phase <= 1'b0;
        wp_enable <= 1'b0;
        for (int m = 0; m < 3; m++)
        begin
            w = 1 << m;
            lane_mode <= m[1:0];
            quad_cmd <= (m == 2);
            u_host.start(1'b0);
            check(selected === 1'b1, "selected");
            d = 8'($random(seed));
            exp_q.push_back(d);
            u_host.send(d, w, 9);
            t = 8'($random(seed));
            tx_byte <= t;
            drive_phase <= 1'b1;
            p0 = take_cnt;
            u_host.recv(w, r, oe);
            oe_x = (m == 0) ? snpi_pkg::OE_SINGLE : ((m == 1) ? snpi_pkg::OE_DUAL : snpi_pkg::OE_QUAD);
            check(r === t, "read byte");
            check(oe === oe_x, "lane enables");
            check(take_cnt - p0 == 1, "one byte load");
            drive_phase <= 1'b0;
            u_host.stop(1'b0);
            $display("test lanes %0d done", w);
        end
        lane_mode <= 2'h0;
        quad_cmd <= 1'b0;
        u_host.start(1'b0);
        p0 = pause_cnt;
        d = 8'($random(seed));
        exp_q.push_back(d);
        u_host.send(d, 1, 3);
        check(pause_cnt - p0 > 5, "pause seen");
        u_host.stop(1'b1);
        u_host.start(1'b1);
        exp_q.push_back(8'h3C);
        u_host.send(8'h3C, 1, 9);
        u_host.stop(1'b1);
        $display("test pause and mode three done");
        for (int i = 0; i < 4; i++)
        begin
            wp_enable <= i[1];
            u_host.wp_n <= i[0];
            bpf <= 4'($random(seed)) | 4'h1;
            spf <= {i[1], 1'b0};
            u_host.ticks(4);
            check(write_block === (i[1] & ~i[0]), "hard protect");
            check(quad_enabled === ~i[1], "quad disable");
            check(region_guard === (i[1] & ~i[0]), "region guard");
            if (i < 2)
                check(prot_reg_guard === ~i[0], "register guard");
        end
        busy_in <= 1'b1;
        u_host.ticks(3);
        check(internal_busy === 1'b1, "busy while deselected");
        t = 8'($random(seed));
        busy_in <= t[0];
        u_host.ticks(3);
        check(internal_busy === t[0], "busy follows input");
        $display("test protect and busy done");
        check(exp_q.size() == 0, "all bytes seen");
        complete_run();
    end
endmodule
`default_nettype wire
